/* rst_audio_pkg.sv */
package rst_audio_pkg;
    // Register indices (printed offsets not all multiples of four)
    localparam logic [31:0] reset_pin_config_idx = 32'h5000_0040;
    localparam logic [31:0] reset_pin_hold_time_idx = 32'h5000_0042;
    localparam logic [31:0] pcm_clock_divider_idx = 32'h5000_1C40;
    localparam logic [31:0] pcm_fraction_pattern_idx = 32'h5000_1C42;
    localparam logic [31:0] pdm_clock_divider_idx = 32'h5000_1C44;
    localparam logic [31:0] rate_conv_clock_divider_idx = 32'h5000_1C46;
    // Word address bits kept by the decoder
    localparam int addr_w = 16;
    // Field positions
    localparam int pin_pol_bit = 7;
    localparam int pin_sel_msb = 5;
    localparam int pcm_en_bit = 12;
    localparam int pcm_div_msb = 11;
    localparam int pdm_master_bit = 9;
    localparam int pdm_en_bit = 8;
    localparam int pdm_divisor_msb = 7;
    localparam int src_en_bit = 8;
    localparam int rate_conv_divisor_msb = 7;
    // Reset values
    localparam logic [7:0] pin_config_rst = 8'h00;
    localparam logic [6:0] hold_time_rst = 7'h18;
    localparam logic [13:0] pcm_div_rst = 14'h0000;
    localparam logic [15:0] pcm_frac_rst = 16'h0000;
    localparam logic [9:0] pdm_divisor_rst = 10'h000;
    localparam logic [8:0] rate_conv_divisor_rst = 9'h000;
    // Slow clock periods per hold-time unit
    localparam int hold_unit_ticks = 4096;
    // Pin select layout
    localparam logic [5:0] sel_none = 6'h00;
    localparam int gpio_count = 32;
endpackage : rst_audio_pkg

/* reset_pin_and_audio_clock_gen.sv */
// Behaviour
// RULE1: GPIO reset pin active low when polarity bit 7 is 0, high when 1.
// RULE2: Polarity applies to GPIO pin only; reset pad always active high.
// RULE3: Select 0 disables; codes 1..32 pick P0_0..P3_7 in order.
// RULE4: Reset fires after pin active for field times 4096 slow clock periods.
// RULE5: Hold counter clears whenever pin goes inactive before expiry.
// RULE6: PCM clock runs only when bit 12 set, divided by bits 11:0.
// RULE7: Software writes divider before or with the enable, never after.
// RULE8: Fraction denominator is position of highest set bit plus one.
// RULE9: Fraction numerator is number of set bits in the pattern.
// RULE10: Walk pattern downward from top set bit, each 1 stretches a period.
// RULE11: PDM clock runs only when bit 8 set, divided by bits 7:0; in slave mode pdm_clk follows pdm_clk_in undivided, whatever bit 8 is.
// RULE12: PDM is clock slave when bit 9 is 0, master when 1.
// RULE13: Rate converter clock runs only when bit 8 set, divided by 7:0.
`timescale 1ns/1ps
module reset_pin_and_audio_clock_gen #(
    parameter int hold_unit = rst_audio_pkg::hold_unit_ticks
) (
    // System
    input wire logic clk,
    input wire logic resetn,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Reset sources
    input wire logic [31:0] gpio_in,
    input wire logic reset_pad,
    input wire logic slow_rc_clock,
    output logic power_on_reset,
    // Audio clocks
    input wire logic pdm_clk_in,
    output logic pcm_clk,
    output logic pdm_clk,
    output logic pdm_clk_oe,
    output logic pdm_clock_master_select,
    output logic rate_conv_clk
);
    initial begin
        if (hold_unit < 1) begin
            $error("hold_unit must be at least one");
        end
    end

    localparam int hu_w = $clog2(hold_unit + 1);

    // Whole state of the block
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [7:0] pin_cfg;
        logic [6:0] hold_time;
        logic [13:0] pcm_div;
        logic [15:0] pcm_frac;
        logic [9:0] pdm_divisor;
        logic [8:0] rate_conv_divisor;
        logic [2:0] pin_s;
        logic [2:0] pad_s;
        logic [2:0] rc_s;
        logic [2:0] pdmi_s;
        logic pin_act;
        logic pad_act;
        logic rc_lvl;
        logic [hu_w-1:0] unit_cnt;
        logic [6:0] hold_cnt;
        logic por;
        logic [12:0] pcm_cnt;
        logic [15:0] frac_mask;
        logic pcm_out;
        logic [7:0] pdm_cnt;
        logic pdm_out;
        logic pdm_in_lvl;
        logic [7:0] src_cnt;
        logic src_out;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // Index of highest set bit, 0 when none
    function automatic logic [4:0] top_bit(input logic [15:0] v);
        logic [4:0] p;
        p = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (v[i]) begin
                p = 5'(i);
            end
        end
        return p;
    endfunction : top_bit

    // Pick the slot of a one-bit field; codes past the last pin pick none
    function automatic logic in_sel(input logic [31:0] v,
                                    input logic [5:0] s);
        return (s == rst_audio_pkg::sel_none
                || s > 6'(rst_audio_pkg::gpio_count)) ? 1'b0
                                                     : v[5'(s - 6'h01)];
    endfunction : in_sel

    // Word address decode; address carries the register index
    function automatic logic hit(input logic [31:0] a, input logic [31:0] idx);
        return a[rst_audio_pkg::addr_w+1:2] == idx[rst_audio_pkg::addr_w-1:0];
    endfunction : hit

    logic req;
    logic [31:0] wmask;
    logic gpio_raw;
    logic pin_raw;
    logic [15:0] frac;
    logic [12:0] pcm_target;
    logic [15:0] rd;

    assign req = cyc_i && stb_i && !st_r.ack;
    assign frac = st_r.pcm_frac;

    // Byte-lane mask from select
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[8*b +: 8] = {8{sel_i[b]}};
        end
    end

    // Raw reset source seen by the pin path
    always_comb begin
        gpio_raw = in_sel(gpio_in,
            st_r.pin_cfg[rst_audio_pkg::pin_sel_msb:0]); // RULE3
        pin_raw = st_r.pin_cfg[rst_audio_pkg::pin_pol_bit] ? gpio_raw
                                                           : !gpio_raw; // RULE1
    end

    // Read data mux
    always_comb begin
        rd = 16'h0000;
        if (hit(adr_i, rst_audio_pkg::reset_pin_config_idx)) begin
            rd = {8'h00, st_r.pin_cfg};
        end else if (hit(adr_i, rst_audio_pkg::reset_pin_hold_time_idx)) begin
            rd = {9'h000, st_r.hold_time};
        end else if (hit(adr_i, rst_audio_pkg::pcm_clock_divider_idx)) begin
            rd = {2'h0, st_r.pcm_div};
        end else if (hit(adr_i, rst_audio_pkg::pcm_fraction_pattern_idx)) begin
            rd = st_r.pcm_frac;
        end else if (hit(adr_i, rst_audio_pkg::pdm_clock_divider_idx)) begin
            rd = {6'h00, st_r.pdm_divisor};
        end else if (hit(adr_i,
                         rst_audio_pkg::rate_conv_clock_divider_idx)) begin
            rd = {7'h00, st_r.rate_conv_divisor};
        end
    end

    // PCM half period: low half one cycle longer while current bit is set,
    // so each set bit stretches its whole period by one source cycle
    assign pcm_target = {1'b0, st_r.pcm_div[rst_audio_pkg::pcm_div_msb:0]}
        + {12'h000, |(st_r.frac_mask & frac) && !st_r.pcm_out}; // RULE10

    // Next-state logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = req;
        st_nxt.rdata = {16'h0000, rd};
        // Register writes
        if (req && we_i) begin
            if (hit(adr_i, rst_audio_pkg::reset_pin_config_idx)) begin
                st_nxt.pin_cfg = (st_r.pin_cfg & ~wmask[7:0])
                    | (dat_i[7:0] & wmask[7:0]);
            end
            if (hit(adr_i, rst_audio_pkg::reset_pin_hold_time_idx)) begin
                st_nxt.hold_time = (st_r.hold_time & ~wmask[6:0])
                    | (dat_i[6:0] & wmask[6:0]);
            end
            if (hit(adr_i, rst_audio_pkg::pcm_clock_divider_idx)) begin
                // Divider and enable land together in one write
                st_nxt.pcm_div = (st_r.pcm_div & ~wmask[13:0])
                    | (dat_i[13:0] & wmask[13:0]); // RULE7
            end
            if (hit(adr_i, rst_audio_pkg::pcm_fraction_pattern_idx)) begin
                st_nxt.pcm_frac = (st_r.pcm_frac & ~wmask[15:0])
                    | (dat_i[15:0] & wmask[15:0]);
            end
            if (hit(adr_i, rst_audio_pkg::pdm_clock_divider_idx)) begin
                st_nxt.pdm_divisor = (st_r.pdm_divisor & ~wmask[9:0])
                    | (dat_i[9:0] & wmask[9:0]);
            end
            if (hit(adr_i, rst_audio_pkg::rate_conv_clock_divider_idx)) begin
                st_nxt.rate_conv_divisor = (st_r.rate_conv_divisor & ~wmask[8:0])
                    | (dat_i[8:0] & wmask[8:0]);
            end
        end
        // Input synchronisers, three stages
        st_nxt.pin_s = {st_r.pin_s[1:0], pin_raw};
        st_nxt.pad_s = {st_r.pad_s[1:0], reset_pad};
        st_nxt.rc_s = {st_r.rc_s[1:0], slow_rc_clock};
        st_nxt.pdmi_s = {st_r.pdmi_s[1:0], pdm_clk_in};
        if (st_r.pin_s[2] == st_r.pin_s[1]) begin
            st_nxt.pin_act = st_r.pin_s[2];
        end
        if (st_r.pad_s[2] == st_r.pad_s[1]) begin
            st_nxt.pad_act = st_r.pad_s[2]; // RULE2
        end
        if (st_r.rc_s[2] == st_r.rc_s[1]) begin
            st_nxt.rc_lvl = st_r.rc_s[2];
        end
        if (st_r.pdmi_s[2] == st_r.pdmi_s[1]) begin
            st_nxt.pdm_in_lvl = st_r.pdmi_s[2];
        end
        // Hold timer counts slow clock rising edges while pin active
        if (!st_r.pin_act
            || st_r.pin_cfg[rst_audio_pkg::pin_sel_msb:0]
               == rst_audio_pkg::sel_none) begin
            st_nxt.unit_cnt = '0; // RULE5
            st_nxt.hold_cnt = 7'h00; // RULE5
        end else if (!st_r.por && st_nxt.rc_lvl && !st_r.rc_lvl) begin
            if (st_r.unit_cnt == hu_w'(hold_unit - 1)) begin
                st_nxt.unit_cnt = '0;
                st_nxt.hold_cnt = st_r.hold_cnt + 7'h01; // RULE4
            end else begin
                st_nxt.unit_cnt = st_r.unit_cnt + hu_w'(1);
            end
        end
        // Reset raised while held long enough or pad active
        st_nxt.por = st_r.pad_act
            || (st_r.pin_act && st_r.hold_cnt >= st_r.hold_time
                && st_r.pin_cfg[rst_audio_pkg::pin_sel_msb:0]
                   != rst_audio_pkg::sel_none); // RULE4
        // PCM divider with fractional stretch
        if (!st_r.pcm_div[rst_audio_pkg::pcm_en_bit]) begin
            st_nxt.pcm_cnt = 13'h0000; // RULE6
            st_nxt.pcm_out = 1'b0;
            st_nxt.frac_mask = 16'h0000;
        end else if (st_r.pcm_cnt + 13'h0001 >= pcm_target) begin
            st_nxt.pcm_cnt = 13'h0000;
            st_nxt.pcm_out = !st_r.pcm_out; // RULE6
            // Advance the fraction pointer once per full period
            if (st_r.pcm_out) begin
                if (st_r.frac_mask <= 16'h0001) begin
                    st_nxt.frac_mask = 16'h0001 << top_bit(frac); // RULE8
                end else begin
                    st_nxt.frac_mask = st_r.frac_mask >> 1; // RULE9
                end
            end
        end else begin
            st_nxt.pcm_cnt = st_r.pcm_cnt + 13'h0001;
        end
        // PDM divider
        if (!st_r.pdm_divisor[rst_audio_pkg::pdm_en_bit]) begin
            st_nxt.pdm_cnt = 8'h00; // RULE11
            st_nxt.pdm_out = 1'b0;
        end else if (st_r.pdm_cnt + 8'h01
                     >= st_r.pdm_divisor[rst_audio_pkg::pdm_divisor_msb:0]) begin
            st_nxt.pdm_cnt = 8'h00;
            st_nxt.pdm_out = !st_r.pdm_out; // RULE11
        end else begin
            st_nxt.pdm_cnt = st_r.pdm_cnt + 8'h01;
        end
        // Rate converter divider
        if (!st_r.rate_conv_divisor[rst_audio_pkg::src_en_bit]) begin
            st_nxt.src_cnt = 8'h00; // RULE13
            st_nxt.src_out = 1'b0;
        end else if (st_r.src_cnt + 8'h01
                     >= st_r.rate_conv_divisor[rst_audio_pkg::rate_conv_divisor_msb:0]) begin
            st_nxt.src_cnt = 8'h00;
            st_nxt.src_out = !st_r.src_out; // RULE13
        end else begin
            st_nxt.src_cnt = st_r.src_cnt + 8'h01;
        end
    end

    // State register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
            st_r.pin_cfg <= rst_audio_pkg::pin_config_rst;
            st_r.hold_time <= rst_audio_pkg::hold_time_rst;
            st_r.pcm_div <= rst_audio_pkg::pcm_div_rst;
            st_r.pcm_frac <= rst_audio_pkg::pcm_frac_rst;
            st_r.pdm_divisor <= rst_audio_pkg::pdm_divisor_rst;
            st_r.rate_conv_divisor <= rst_audio_pkg::rate_conv_divisor_rst;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs
    assign ack_o = st_r.ack;
    assign dat_o = st_r.rdata;
    assign power_on_reset = st_r.por;
    assign pcm_clk = st_r.pcm_out;
    assign pdm_clock_master_select =
        st_r.pdm_divisor[rst_audio_pkg::pdm_master_bit];
    assign pdm_clk = pdm_clock_master_select ? st_r.pdm_out
                                             : st_r.pdm_in_lvl; // RULE12
    assign pdm_clk_oe = pdm_clock_master_select; // RULE12
    assign rate_conv_clk = st_r.src_out;

    // Checks, all on the system clock
    default clocking chk_cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Pin selected, held active and its programmed time used up
    sequence pin_expired;
        st_r.pin_act && st_r.hold_cnt >= st_r.hold_time
            && st_r.pin_cfg[rst_audio_pkg::pin_sel_msb:0]
               != rst_audio_pkg::sel_none;
    endsequence

    // Neither reset source active
    sequence sources_idle;
        !st_r.pad_act && !st_r.pin_act;
    endsequence

    a_pad_forces_reset: assert property ( // RULE2
        st_r.pad_act |=> power_on_reset)
        else $error("pad active did not raise reset");
    a_sel_zero_idle: assert property ( // RULE3
        st_r.pin_cfg[rst_audio_pkg::pin_sel_msb:0] == rst_audio_pkg::sel_none
        && !st_r.pad_act |=> !power_on_reset)
        else $error("reset with pin disabled");
    a_hold_clears: assert property ( // RULE5
        !st_r.pin_act |=> st_r.hold_cnt == 7'h00)
        else $error("hold counter kept on release");
    a_pin_pol: assert property ( // RULE1
        pin_raw == (gpio_raw ~^ st_r.pin_cfg[rst_audio_pkg::pin_pol_bit]))
        else $error("pin polarity wrong");
    a_hold_expiry: assert property ( // RULE4
        pin_expired |=> power_on_reset)
        else $error("reset missing after hold time");
    a_por_release: assert property ( // RULE4
        sources_idle |=> !power_on_reset)
        else $error("reset without an active source");
    a_pcm_off: assert property ( // RULE6
        !st_r.pcm_div[rst_audio_pkg::pcm_en_bit] |=> !pcm_clk)
        else $error("pcm clock while disabled");
    a_pdm_off: assert property ( // RULE11
        !st_r.pdm_divisor[rst_audio_pkg::pdm_en_bit] |=> !st_r.pdm_out)
        else $error("pdm clock while disabled");
    a_src_off: assert property ( // RULE13
        !st_r.rate_conv_divisor[rst_audio_pkg::src_en_bit] |=> !rate_conv_clk)
        else $error("src clock while disabled");
    a_pdm_mode: assert property ( // RULE12
        pdm_clk_oe == st_r.pdm_divisor[rst_audio_pkg::pdm_master_bit])
        else $error("pdm direction wrong");
    a_frac_start: assert property ( // RULE8
        $rose(st_r.pcm_div[rst_audio_pkg::pcm_en_bit])
        |-> st_r.frac_mask == 16'h0000)
        else $error("fraction pointer not reset");
    a_frac_step: assert property ( // RULE10
        $past(st_r.pcm_div[rst_audio_pkg::pcm_en_bit])
        && $past(st_r.frac_mask) > 16'h0001 && $changed(st_r.frac_mask)
        |-> st_r.frac_mask == $past(st_r.frac_mask) >> 1)
        else $error("fraction pointer skipped a bit");
endmodule : reset_pin_and_audio_clock_gen

/* reset_button_model.sv */
`timescale 1ns/1ps
module reset_button_model (
    // System
    input wire logic clk,
    input wire logic resetn,
    // Bench control
    input wire logic [4:0] btn_idx,
    input wire logic btn_high,
    input wire logic pressed,
    input wire logic pdm_run,
    // Pins seen by the block
    output logic [31:0] gpio_in,
    output logic slow_rc_clock,
    output logic pdm_clk_in
);
    logic [3:0] rc_cnt_r;
    logic [1:0] pdm_cnt_r;
    logic pdm_r;
    // Free running RC oscillator, ten system cycles a period
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rc_cnt_r <= 4'h0;
            pdm_cnt_r <= 2'h0;
            pdm_r <= 1'b0;
        end else begin
            rc_cnt_r <= (rc_cnt_r == 4'h9) ? 4'h0 : rc_cnt_r + 4'h1;
            pdm_cnt_r <= (pdm_cnt_r == 2'h2) ? 2'h0 : pdm_cnt_r + 2'h1;
            if (!pdm_run)
                pdm_r <= 1'b0; // Held low when not streaming
            else if (pdm_cnt_r == 2'h2)
                pdm_r <= ~pdm_r;
        end
    end
    assign slow_rc_clock = rc_cnt_r < 4'h5;
    assign pdm_clk_in = pdm_r;
    // Pressed pin at its active level, every other pin idle
    always_comb begin
        gpio_in = {32{~btn_high}};
        if (pressed)
            gpio_in[btn_idx] = btn_high;
    end
endmodule : reset_button_model

/* reset_pin_and_audio_clock_gen_tb.sv */
`timescale 1ns/1ps
module reset_pin_and_audio_clock_gen_tb;
    localparam logic [31:0] r_cfg = rst_audio_pkg::reset_pin_config_idx;
    localparam logic [31:0] r_hld = rst_audio_pkg::reset_pin_hold_time_idx;
    localparam logic [31:0] r_pcm = rst_audio_pkg::pcm_clock_divider_idx;
    localparam logic [31:0] r_frc = rst_audio_pkg::pcm_fraction_pattern_idx;
    localparam logic [31:0] r_pdm = rst_audio_pkg::pdm_clock_divider_idx;
    localparam logic [31:0] r_src = rst_audio_pkg::rate_conv_clock_divider_idx;
    // Bench and design signals
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, reset_pad = 1'b0;
    logic [31:0] adr_i = 32'h0, dat_i = 32'h0, dat_o, gpio_in;
    logic [3:0] sel_i = 4'hF;
    logic ack_o, slow_rc_clock, power_on_reset, pdm_clk_in, pcm_clk;
    logic pdm_clk, pdm_clk_oe, pdm_clock_master_select, rate_conv_clk;
    logic [4:0] btn_idx = 5'h00;
    logic btn_high = 1'b0, pressed = 1'b0, pdm_run = 1'b0;
    int n_fail = 0, n_checks = 0, cycles = 0;
    logic ack_s, por_s, pcm_s, pdm_s, src_s, oe_s, ms_s;
    logic [31:0] dat_s;
    // Clock
    always #50 clk = ~clk;
    reset_pin_and_audio_clock_gen #(.hold_unit(4)) uut (.clk, .resetn,
        .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .gpio_in, .reset_pad, .slow_rc_clock, .power_on_reset, .pdm_clk_in,
        .pcm_clk, .pdm_clk, .pdm_clk_oe, .pdm_clock_master_select,
        .rate_conv_clk);
    reset_button_model btn (.clk, .resetn, .btn_idx, .btn_high, .pressed,
        .pdm_run, .gpio_in, .slow_rc_clock, .pdm_clk_in);
    // Outputs taken mid-cycle, once settled, for use at the next rising edge
    always @(negedge clk) begin
        ack_s <= ack_o;
        dat_s <= dat_o;
        por_s <= power_on_reset;
        pcm_s <= pcm_clk;
        pdm_s <= pdm_clk;
        src_s <= rate_conv_clk;
        oe_s <= pdm_clk_oe;
        ms_s <= pdm_clock_master_select;
    end
    // Cut a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_fail = n_fail + 1;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done
    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Classic single cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [31:0] idx,
            input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {14'h0000, idx[15:0], 2'h0};
        dat_i <= d;
        // Wait for ack as it stands at a rising edge; the timeout ends a hang
        do begin
            @(posedge clk);
        end while (ack_s !== 1'b1);
        q = dat_s;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk);
    endtask : wb
    task automatic wr(input logic [31:0] idx, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, idx, d, q);
    endtask : wr
    task automatic rd(input string what, input logic [31:0] idx,
            input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, idx, 32'h0, q);
        check(what, q, exp);
    endtask : rd
    function automatic logic pick(input int w);
        return w == 0 ? pcm_s : (w == 1 ? pdm_s : src_s);
    endfunction : pick
    // Cycles up to the next rise of a clock; 201 when none comes
    task automatic gap(input int w, output int n);
        logic p, c;
        p = pick(w);
        for (n = 1; n <= 200; n++) begin
            @(posedge clk);
            c = pick(w);
            if (!p && c)
                break;
            p = c;
        end
    endtask : gap
    task automatic wait_por(input int lim, output int n);
        for (n = 0; n < lim; n++) begin
            @(posedge clk);
            if (por_s === 1'b1)
                break;
        end
    endtask : wait_por
    task automatic t_regs();
        logic [31:0] ix[6] = '{r_cfg, r_hld, r_pcm, r_frc, r_pdm, r_src};
        logic [31:0] rv[6] = '{32'h0, 32'h18, 32'h0, 32'h0, 32'h0, 32'h0};
        logic [31:0] mk[6] = '{32'hFF, 32'h7F, 32'h3FFF, 32'hFFFF,
            32'h3FF, 32'h1FF};
        foreach (ix[i]) rd("reset value", ix[i], rv[i]);
        foreach (ix[i]) begin
            wr(ix[i], 32'hFFFF_FFFF);
            rd("read back", ix[i], mk[i]);
            wr(ix[i], rv[i]);
        end
        wr(32'h1C48, 32'hFFFF_FFFF);
        rd("unmapped", 32'h1C48, 32'h0);
        rd("neighbour", r_src, 32'h0);
    endtask : t_regs
    task automatic t_pcm();
        int n, s;
        wr(r_pcm, 32'h1003);
        gap(0, n);
        gap(0, n);
        check("pcm period", n, 6);
        for (int f = 0; f < 2; f++) begin
            wr(r_pcm, 32'h0003);
            wr(r_frc, f ? 32'h0110 : 32'h0005);
            wr(r_pcm, 32'h1003);
            gap(0, n);
            s = 0;
            for (int i = 0; i < (f ? 9 : 3); i++) begin
                gap(0, n);
                s += n;
            end
            check("pcm frac sum", s, f ? 56 : 20);
        end
        wr(r_pcm, 32'h0003);
        gap(0, n);
        check("pcm gated", n, 201);
        wr(r_frc, 32'h0);
    endtask : t_pcm
    task automatic t_pdm_src();
        int n;
        wr(r_pdm, 32'h0302);
        gap(1, n);
        gap(1, n);
        check("pdm master period", n, 4);
        check("pdm drive", {oe_s, ms_s}, 3);
        pdm_run <= 1'b1;
        wr(r_pdm, 32'h0102);
        gap(1, n);
        gap(1, n);
        check("pdm slave period", n, 6);
        check("pdm released", {oe_s, ms_s}, 0);
        pdm_run <= 1'b0;
        wr(r_pdm, 32'h0202);
        gap(1, n);
        check("pdm gated", n, 201);
        wr(r_src, 32'h0104);
        gap(2, n);
        gap(2, n);
        check("src period", n, 8);
        wr(r_src, 32'h0004);
        gap(2, n);
        check("src gated", n, 201);
    endtask : t_pdm_src
    task automatic t_por(input int pin, input logic hi);
        int n;
        wr(r_cfg, {24'h0, hi, 1'h0, 6'(pin + 1)});
        btn_high <= hi;
        btn_idx <= 5'(pin ^ 1);
        pressed <= 1'b1;
        wait_por(160, n);
        check("other pin", n, 160);
        pressed <= 1'b0;
        btn_idx <= 5'(pin);
        repeat (20) @(posedge clk);
        pressed <= 1'b1;
        repeat (40) @(posedge clk);
        pressed <= 1'b0;
        repeat (20) @(posedge clk);
        check("short press", por_s, 1'b0);
        pressed <= 1'b1;
        wait_por(160, n);
        check("hold time", n >= 70 && n <= 95, 1'b1);
        pressed <= 1'b0;
        repeat (8) @(posedge clk);
        check("released", por_s, 1'b0);
    endtask : t_por
    task automatic t_pad();
        int n;
        for (int p = 0; p < 2; p++) begin
            wr(r_cfg, {24'h0, p[0], 7'h00});
            btn_high <= p[0];
            reset_pad <= 1'b1;
            wait_por(20, n);
            check("pad reset", n < 10, 1'b1);
            reset_pad <= 1'b0;
            repeat (10) @(posedge clk);
            check("pad release", por_s, 1'b0);
        end
        btn_idx <= 5'h00;
        pressed <= 1'b1;
        wait_por(160, n);
        check("select none", n, 160);
        pressed <= 1'b0;
    endtask : t_pad
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        t_pcm();
        t_pdm_src();
        wr(r_hld, 32'h2);
        t_por(0, 1'b0);
        t_por(13, 1'b1);
        t_por(31, 1'b0);
        t_pad();
        test_done();
    end
endmodule : reset_pin_and_audio_clock_gen_tb
